// ---- logic/rwa_defs.svh ----
// Constants of the receive word aligner and rate-match status block.
// Included by the top module and the testbench; holds definitions only.
`ifndef RWA_DEFS_SVH
`define RWA_DEFS_SVH

`define RWA_OFF_CTRL 8'h00
`define RWA_OFF_ALIGN_PAT 8'h04
`define RWA_OFF_RM_PAT 8'h08
`define RWA_OFF_RL_THR 8'h0C
`define RWA_OFF_STATUS 8'h10
`define RWA_OFF_IRQ_STAT 8'h14
`define RWA_OFF_IRQ_MASK 8'h18

`define RWA_CTRL_MODE_LSB 0
`define RWA_CTRL_BYTE_SER 2
`define RWA_CTRL_RM_EN 3

`define RWA_RST_CTRL 4'h0
`define RWA_RST_ALIGN_PAT 10'h17C
`define RWA_RST_RM_PAT 10'h2F8
`define RWA_RST_RL_THR 8'h10
`define RWA_RST_IRQ_MASK 5'h00

`define RWA_IRQ_RLV 0
`define RWA_IRQ_INS 1
`define RWA_IRQ_DEL 2
`define RWA_IRQ_SYNC_ON 3
`define RWA_IRQ_SYNC_OFF 4

`define RWA_RLV_CYC_PLAIN 2'd2
`define RWA_RLV_CYC_BYTE_SER 2'd3

`define RWA_RESP_OKAY 2'b00
`define RWA_RESP_SLVERR 2'b10

`endif

// ---- logic/rwa_pkg.sv ----
// Types of the receive word aligner and rate-match status block.
// Assumes nothing beyond the constants header.
`default_nettype none
package rwa_pkg;
    // Gray order along auto, manual, bit-slip.
    typedef enum logic [1:0] {
        RWA_MODE_AUTO = 2'b00,
        RWA_MODE_MANUAL = 2'b01,
        RWA_MODE_BITSLIP = 2'b11
    } rwa_mode_t;
endpackage
`default_nettype wire

// ---- logic/rwa_top.sv ----
// Receive word aligner with polarity inversion, run-length check, rate matching
// and an AXI4-Lite register file with a read-to-clear interrupt status.
// Assumes all pin inputs are synchronous to aclk, which stands for the selected parallel clock.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rwa_defs.svh"

// Operation
// - Sync status travels with the aligned word while rate matching is off and is held low in bit-slip mode.
// - Sync status is clocked by the single selected parallel clock of this channel.
// - Pattern detect rises whenever the programmed pattern sits on the current boundary.
// - In bit-slip mode each rising slip request moves the boundary one bit.
// - Run-length violation pulses when identical bits exceed the programmed threshold.
// - The violation pulse lasts two cycles, or three with a byte serializer.
// - Polarity control high inverts every bit of the word before alignment.
// - In manual mode the pattern-align enable gates the boundary search.
// - Insertion status goes high when a rate-match pattern word is repeated.
// - Deletion status goes high when a rate-match pattern word is dropped.
module rwa_top import rwa_pkg::*; #(
    parameter int WORD_W = 10,
    parameter int RM_DEPTH = 4
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received parallel words, bit 0 first on the line.
    input wire logic [WORD_W-1:0] rx_word,
    input wire logic rx_valid,
    // Fabric controls.
    input wire logic rx_pol_invert,
    input wire logic pattern_align_en,
    input wire logic bitslip_req,
    // Aligned words and status.
    output logic [WORD_W-1:0] word_out,
    output logic word_out_valid,
    output logic word_sync_status,
    output logic pattern_detect,
    output logic run_length_viol,
    output logic rm_inserted,
    output logic rm_deleted,
    output logic irq
);
    localparam int OFF_W = 4;
    localparam int PTR_W = $clog2(RM_DEPTH);

    initial begin
        if (!(WORD_W == 8 || WORD_W == 10) || RM_DEPTH < 4 || RM_DEPTH != (1 << PTR_W)) begin
            $error("rwa_top: WORD_W must be 8 or 10 and RM_DEPTH a power of two of at least 4.");
        end
    end

    logic [3:0] ctrl_q;
    logic [WORD_W-1:0] align_pat_q, rm_pat_q;
    logic [7:0] rl_thr_q;
    logic [4:0] irq_stat_q, irq_mask_q, irq_ev;
    rwa_mode_t mode;
    assign mode = rwa_mode_t'(ctrl_q[`RWA_CTRL_MODE_LSB +: 2]);

    // Word path: inversion, two-word window, boundary select.
    logic [WORD_W-1:0] pol_word, prev_q, aligned;
    logic [2*WORD_W-1:0] window;
    logic [OFF_W-1:0] off_q, found_off;
    logic found, on_boundary, slip_prev_q, sync_q;

    assign pol_word = rx_pol_invert ? ~rx_word : rx_word;
    assign window = {pol_word, prev_q};
    assign aligned = window[off_q +: WORD_W];
    assign on_boundary = (aligned == align_pat_q);

    always_comb begin
        found = 1'b0;
        found_off = '0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (window[i +: WORD_W] == align_pat_q) begin
                found = 1'b1;
                found_off = OFF_W'(i);
            end
        end
    end

    logic search_ok, slip_edge;
    // Manual mode searches only while the fabric enables it.
    assign search_ok = (mode == RWA_MODE_AUTO) || (mode == RWA_MODE_MANUAL && pattern_align_en);
    assign slip_edge = bitslip_req && !slip_prev_q && (mode == RWA_MODE_BITSLIP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= '0;
            off_q <= '0;
            slip_prev_q <= 1'b0;
        end else begin
            slip_prev_q <= bitslip_req;
            if (rx_valid) begin
                prev_q <= pol_word;
            end
            if (slip_edge) begin
                off_q <= (off_q == OFF_W'(WORD_W - 1)) ? '0 : off_q + 1'b1;
            end else if (rx_valid && search_ok && !sync_q && !on_boundary && found) begin
                off_q <= found_off;
            end
        end
    end

    // Sync and detect flops share the one parallel clock, so they stay aligned to word_out while rate matching is off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_q <= 1'b0;
            pattern_detect <= 1'b0;
        end else if (mode == RWA_MODE_BITSLIP) begin
            sync_q <= 1'b0;
            pattern_detect <= rx_valid && on_boundary;
        end else if (rx_valid) begin
            pattern_detect <= on_boundary;
            if (on_boundary && search_ok) begin
                sync_q <= 1'b1;
            end else if (found && !on_boundary && search_ok) begin
                sync_q <= 1'b0;
            end
        end
    end
    assign word_sync_status = sync_q;

    // Run-length check over the inverted stream in line order.
    logic rl_last_q, rl_viol;
    logic [7:0] rl_run_q, rl_run_d;
    logic [1:0] rlv_cnt_q;
    always_comb begin
        logic last;
        last = rl_last_q;
        rl_run_d = rl_run_q;
        rl_viol = 1'b0;
        for (int i = 0; i < WORD_W; i++) begin
            if (pol_word[i] == last && rl_run_d != 8'hFF) begin
                rl_run_d = rl_run_d + 8'h01;
            end else if (pol_word[i] != last) begin
                rl_run_d = 8'h01;
            end
            last = pol_word[i];
            if (rl_run_d > rl_thr_q) begin
                rl_viol = rx_valid;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rl_last_q <= 1'b0;
            rl_run_q <= '0;
            rlv_cnt_q <= '0;
            run_length_viol <= 1'b0;
        end else begin
            if (rx_valid) begin
                rl_last_q <= pol_word[WORD_W-1];
                rl_run_q <= rl_run_d;
            end
            if (rl_viol) begin
                rlv_cnt_q <= ctrl_q[`RWA_CTRL_BYTE_SER] ? `RWA_RLV_CYC_BYTE_SER : `RWA_RLV_CYC_PLAIN;
            end else if (rlv_cnt_q != 2'd0) begin
                rlv_cnt_q <= rlv_cnt_q - 2'd1;
            end
            run_length_viol <= rl_viol || (rlv_cnt_q > 2'd1);
        end
    end

    // Rate match: a small elastic store that drops or repeats pattern words.
    logic [WORD_W-1:0] rm_mem [RM_DEPTH];
    logic [PTR_W-1:0] rm_wr_q, rm_rd_q;
    logic [PTR_W:0] rm_occ_q;
    logic rm_en, rm_del, rm_ins, rm_push, rm_pop;
    assign rm_en = ctrl_q[`RWA_CTRL_RM_EN];
    assign rm_del = rm_en && rx_valid && aligned == rm_pat_q && rm_occ_q >= (PTR_W+1)'(RM_DEPTH - 1);
    assign rm_push = rm_en && rx_valid && !rm_del && rm_occ_q != (PTR_W+1)'(RM_DEPTH);
    assign rm_ins = rm_en && rm_occ_q == (PTR_W+1)'(1) && !rm_push && rm_mem[rm_rd_q] == rm_pat_q;
    assign rm_pop = rm_en && rm_occ_q != '0 && !rm_ins;

    always_ff @(posedge aclk) begin
        if (rm_push) begin
            rm_mem[rm_wr_q] <= aligned;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !rm_en) begin
            rm_wr_q <= '0;
            rm_rd_q <= '0;
            rm_occ_q <= '0;
        end else begin
            rm_wr_q <= rm_wr_q + PTR_W'(rm_push);
            rm_rd_q <= rm_rd_q + PTR_W'(rm_pop);
            rm_occ_q <= rm_occ_q + (PTR_W+1)'(rm_push) - (PTR_W+1)'(rm_pop);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_out <= '0;
            word_out_valid <= 1'b0;
            rm_inserted <= 1'b0;
            rm_deleted <= 1'b0;
        end else begin
            word_out <= rm_en ? rm_mem[rm_rd_q] : aligned;
            word_out_valid <= rm_en ? (rm_pop || rm_ins) : rx_valid;
            rm_inserted <= rm_ins;
            rm_deleted <= rm_del;
        end
    end

    // Interrupts: sticky events, set wins over the read clear.
    assign irq_ev = {sync_q && rx_valid && !on_boundary && found && search_ok,
                     rx_valid && on_boundary && search_ok && !sync_q && mode != RWA_MODE_BITSLIP,
                     rm_del, rm_ins, rl_viol};

    // AXI4-Lite slave: one write and one read in flight, one-cycle ready pulses.
    logic wr_take, rd_take, stat_rd;
    assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_take = s_axi_arready && s_axi_arvalid;
    assign stat_rd = rd_take && s_axi_araddr == `RWA_OFF_IRQ_STAT;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Merged write values; a part-select cannot be taken of a call result directly.
    logic [31:0] m_ctrl, m_align, m_rm, m_thr, m_mask;
    assign m_ctrl = merge({28'h0, ctrl_q}, s_axi_wdata, s_axi_wstrb);
    assign m_align = merge(32'(align_pat_q), s_axi_wdata, s_axi_wstrb);
    assign m_rm = merge(32'(rm_pat_q), s_axi_wdata, s_axi_wstrb);
    assign m_thr = merge({24'h0, rl_thr_q}, s_axi_wdata, s_axi_wstrb);
    assign m_mask = merge({27'h0, irq_mask_q}, s_axi_wdata, s_axi_wstrb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RWA_RESP_OKAY;
            ctrl_q <= `RWA_RST_CTRL;
            align_pat_q <= WORD_W'(`RWA_RST_ALIGN_PAT);
            rm_pat_q <= WORD_W'(`RWA_RST_RM_PAT);
            rl_thr_q <= `RWA_RST_RL_THR;
            irq_mask_q <= `RWA_RST_IRQ_MASK;
        end else begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
            s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RWA_RESP_OKAY;
                case (s_axi_awaddr)
                    `RWA_OFF_CTRL: ctrl_q <= m_ctrl[3:0];
                    `RWA_OFF_ALIGN_PAT: align_pat_q <= m_align[WORD_W-1:0];
                    `RWA_OFF_RM_PAT: rm_pat_q <= m_rm[WORD_W-1:0];
                    `RWA_OFF_RL_THR: rl_thr_q <= m_thr[7:0];
                    `RWA_OFF_IRQ_MASK: irq_mask_q <= m_mask[4:0];
                    `RWA_OFF_STATUS, `RWA_OFF_IRQ_STAT: s_axi_bresp <= `RWA_RESP_OKAY;
                    default: s_axi_bresp <= `RWA_RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RWA_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RWA_RESP_OKAY;
                case (s_axi_araddr)
                    `RWA_OFF_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
                    `RWA_OFF_ALIGN_PAT: s_axi_rdata <= 32'(align_pat_q);
                    `RWA_OFF_RM_PAT: s_axi_rdata <= 32'(rm_pat_q);
                    `RWA_OFF_RL_THR: s_axi_rdata <= {24'h0, rl_thr_q};
                    `RWA_OFF_STATUS: s_axi_rdata <= {20'h0, 4'(rm_occ_q), off_q, 2'h0, pattern_detect, sync_q};
                    `RWA_OFF_IRQ_STAT: s_axi_rdata <= {27'h0, irq_stat_q};
                    `RWA_OFF_IRQ_MASK: s_axi_rdata <= {27'h0, irq_mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RWA_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (stat_rd ? 5'h00 : irq_stat_q) | irq_ev;
            irq <= |(((stat_rd ? 5'h00 : irq_stat_q) | irq_ev) & irq_mask_q);
        end
    end

    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sync_off_bitslip;
        (mode == RWA_MODE_BITSLIP) |=> !word_sync_status;
    endproperty
    a_sync_off_bitslip: assert property (p_sync_off_bitslip) else $error("sync status high in bit-slip mode");

    property p_sync_needs_pattern;
        $rose(word_sync_status) |-> $past(rx_valid && on_boundary);
    endproperty
    a_sync_needs_pattern: assert property (p_sync_needs_pattern) else $error("sync rose without pattern");

    property p_detect;
        (rx_valid && on_boundary) |=> pattern_detect;
    endproperty
    a_detect: assert property (p_detect) else $error("pattern detect missed");

    property p_slip_one;
        slip_edge |=> off_q == (($past(off_q) == OFF_W'(WORD_W - 1)) ? '0 : $past(off_q) + 1'b1);
    endproperty
    a_slip_one: assert property (p_slip_one) else $error("bit slip did not move boundary one bit");

    property p_rlv_rise;
        rl_viol |=> run_length_viol;
    endproperty
    a_rlv_rise: assert property (p_rlv_rise) else $error("run-length violation not flagged");

    property p_rlv_width;
        $rose(run_length_viol) && !ctrl_q[`RWA_CTRL_BYTE_SER] |-> run_length_viol [*2];
    endproperty
    a_rlv_width: assert property (p_rlv_width) else $error("run-length pulse too short");

    property p_rlv_width_ser;
        $rose(run_length_viol) && ctrl_q[`RWA_CTRL_BYTE_SER] |-> run_length_viol [*3];
    endproperty
    a_rlv_width_ser: assert property (p_rlv_width_ser) else $error("run-length pulse too short with serializer");

    property p_invert;
        rx_valid && rx_pol_invert |=> prev_q == ~$past(rx_word);
    endproperty
    a_invert: assert property (p_invert) else $error("polarity inversion not applied");

    property p_manual_hold;
        (mode == RWA_MODE_MANUAL && !pattern_align_en && !slip_edge) |=> $stable(off_q);
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("boundary moved without align enable");

    property p_ins;
        rm_ins |=> rm_inserted ##0 word_out == rm_pat_q;
    endproperty
    a_ins: assert property (p_ins) else $error("insertion status or word wrong");

    property p_del;
        rm_del |=> rm_deleted ##0 $stable(rm_wr_q);
    endproperty
    a_del: assert property (p_del) else $error("deleted word was stored");
endmodule
`default_nettype wire

// ---- tb/rwa_fabric_model.sv ----
// Fabric-side model that drives the slip request and the polarity control.
// Assumes one clock, aclk, shared with the aligner; commands come from the bench.
`timescale 1ns/1ps
`default_nettype none
module rwa_fabric_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bench commands.
    input wire logic slip_cmd,
    input wire logic pol_cmd,
    // Pins toward the aligner.
    output logic bitslip_req,
    output var logic rx_pol_invert
);
    logic [1:0] slip_cnt_q;
    logic [1:0] pol_age_q;
    // Two cycles high, then two low, so that each slip is seen once.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slip_cnt_q <= 2'h0;
        end else if (slip_cnt_q != 2'h0) begin
            slip_cnt_q <= slip_cnt_q - 2'h1;
        end else if (slip_cmd) begin
            slip_cnt_q <= 2'h3;
        end
    end
    assign bitslip_req = slip_cnt_q[1];
    // A new polarity level is taken only after the old one stood two cycles.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pol_invert <= 1'b0;
            pol_age_q <= 2'h0;
        end else if (pol_cmd != rx_pol_invert && pol_age_q != 2'h0) begin
            rx_pol_invert <= pol_cmd;
            pol_age_q <= 2'h0;
        end else if (pol_age_q != 2'h3) begin
            pol_age_q <= pol_age_q + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/rwa_top_tb.sv ----
// Self-checking bench of the aligner: register reset values, slip, manual search,
// polarity, run-length pulse width and the read-to-clear interrupt.
// Assumes the design files and the fabric model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rwa_defs.svh"
module rwa_top_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [9:0] rx_word = 10'h000, word_out;
    logic rx_valid = 1'b0, align_en = 1'b0, slip_cmd = 1'b0, pol_cmd = 1'b0, slip, pol;
    logic wov, sync, detect, rlv, ins, del, irq;
    int miscompares = 0, n_compared = 0, rlv_hi = 0;
    logic [31:0] rd, rsp;
    logic [41:0] rows [6] = '{{8'h00, 32'h0, 2'b00}, {8'h04, 32'h17C, 2'b00}, {8'h08, 32'h2F8, 2'b00},
        {8'h0C, 32'h10, 2'b00}, {8'h18, 32'h0, 2'b00}, {8'h1C, 32'h0, 2'b10}};
    always #25 aclk = ~aclk;
    always @(negedge aclk) if (rlv === 1'b1) rlv_hi++;
    rwa_top rwa_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_word(rx_word),
        .rx_valid(rx_valid), .rx_pol_invert(pol), .pattern_align_en(align_en), .bitslip_req(slip),
        .word_out(word_out), .word_out_valid(wov), .word_sync_status(sync), .pattern_detect(detect),
        .run_length_viol(rlv), .rm_inserted(ins), .rm_deleted(del), .irq(irq));
    rwa_fabric_model rwa_fabric_model_inst (.aclk(aclk), .aresetn(aresetn), .slip_cmd(slip_cmd),
        .pol_cmd(pol_cmd), .bitslip_req(slip), .rx_pol_invert(pol));
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Ready is looked at before the edge, so valid drops right after the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && awready === 1'b1;
            tw = pw && wready === 1'b1;
            @(posedge aclk);
            if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
            if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = {30'h0, bresp};
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [31:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = {30'h0, rresp};
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic send(input logic [9:0] w, input int n);
        repeat (n) begin
            @(posedge aclk);
            rx_word <= w; rx_valid <= 1'b1;
        end
        @(negedge aclk);
    endtask
    task automatic slip_once();
        @(posedge aclk) slip_cmd <= 1'b1;
        @(posedge aclk) slip_cmd <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            rdr(rows[i][41:34], rd, rsp);
            chk(rd, rows[i][33:2]);
            chk(rsp, {30'h0, rows[i][1:0]});
        end
        wr(8'h1C, 32'h3, rsp);
        chk(rsp, {30'h0, `RWA_RESP_SLVERR});
        // Bit-slip mode: two slips move the boundary by two, sync stays low.
        wr(`RWA_OFF_CTRL, 32'h3, rsp);
        slip_once();
        slip_once();
        send(10'h17C, 4);
        rdr(`RWA_OFF_STATUS, rd, rsp);
        chk(rd & 32'hF1, 32'h20);
        chk({31'h0, sync}, 32'h0);
        // Manual mode searches only while the enable is high.
        wr(`RWA_OFF_CTRL, 32'h1, rsp);
        send(10'h17C, 6);
        chk({31'h0, sync}, 32'h0);
        align_en <= 1'b1;
        send(10'h17C, 6);
        chk({29'h0, sync, detect, wov}, 32'h7);
        chk({22'h0, word_out}, 32'h17C);
        align_en <= 1'b0;
        // Inverted line data comes out in true polarity.
        wr(`RWA_OFF_CTRL, 32'h0, rsp);
        pol_cmd <= 1'b1;
        send(10'h283, 8);
        chk({22'h0, word_out}, 32'h17C);
        chk({30'h0, sync, detect}, 32'h3);
        pol_cmd <= 1'b0;
        // A run of twenty zeros against a threshold of twelve gives one pulse.
        wr(`RWA_OFF_RL_THR, 32'hC, rsp);
        wr(`RWA_OFF_IRQ_MASK, 32'h1, rsp);
        rdr(`RWA_OFF_IRQ_STAT, rd, rsp);
        for (int ser = 0; ser < 2; ser++) begin
            wr(`RWA_OFF_CTRL, ser << 2, rsp);
            repeat (3) @(negedge aclk);
            chk({31'h0, irq}, 32'h0);
            rlv_hi = 0;
            send(10'h000, 2);
            send(10'h155, 6);
            repeat (4) @(negedge aclk);
            chk(rlv_hi, 2 + ser);
            chk({31'h0, irq}, 32'h1);
            rdr(`RWA_OFF_IRQ_STAT, rd, rsp);
            chk(rd & 32'h1, 32'h1);
        end
        // Rate match in bit-slip mode: a gap after pattern words repeats the last one.
        wr(`RWA_OFF_CTRL, 32'hB, rsp);
        send(10'h2F8, 4);
        rx_valid <= 1'b0;
        repeat (3) @(negedge aclk);
        chk({30'h0, ins, del}, 32'h2);
        chk({22'h0, word_out}, 32'h2F8);
        chk({31'h0, irq}, 32'h0);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
